// file: src/adc_cfg_pkg.sv
// Constants, carrier types and helpers of the converter mode config port.
// How it works
// - Sleep powers down all channels, references and the clock multiplier.
// - Conversions are flagged invalid for 2 ms after sleep is released.
// - Nap powers down chosen channels; references and multiplier stay up.
// - Strap high makes the four port pins static mode inputs.
// - Strap low makes the four pins a serial register port.
// - Chip select low starts; first 16 rising clocks sampled; high ends.
// - Read flag low writes the eight data bits to the addressed register.
// - Read flag high: data returned, register kept, input data ignored.
// - Data out is open drain and only ever pulls low.
// - Strap mode: select pin low two lanes 16-bit, high one lane 14-bit.
// - Strap mode: clock pin low 3.5 mA drive, high 1.75 mA drive.
// - Strap mode: data-in pin low normal, high sleeps the converter.
// - Strap mode: data-out pin low termination off, high termination on.
// - Writing one to bit 7 of register 0 resets; bit self-clears.
// - Soft reset clears all mode registers and briefly sleeps the core.
// - Format bit 7 set disables the duty-cycle stabilizer.
// - Format bit 6 set enables the output scrambler.
// - Format bit 5 set selects two's complement, clear offset binary.
// - Bit 4 forces sleep over all; else bits 3..0 nap channels.
// - Scrambler XORs output LSB into all other data bits.
// - In strap mode the duty-cycle stabilizer stays enabled.
// - Output is offset binary unless two's complement is selected.
`default_nettype none

package adc_cfg_pkg;

  // Timing.
  localparam int unsigned CLOCK_HZ          = 50_000_000;
  localparam int unsigned SLEEP_WAKE_MS     = 2;
  localparam int unsigned SLEEP_WAKE_CYCLES =
    SLEEP_WAKE_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SOFT_RESET_CYCLES = 4;

  // Serial word layout.
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned HEAD_BITS = 8;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned DATA_W    = 8;

  // Register offsets and reset values.
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT_PD  = 7'h01;
  localparam logic [7:0] FORMAT_RESET    = 8'h00;

  // Field positions.
  localparam int unsigned RESET_BIT    = 7;
  localparam int unsigned DCS_OFF_BIT  = 7;
  localparam int unsigned SCRAMBLE_BIT = 6;
  localparam int unsigned SIGNED_BIT   = 5;
  localparam int unsigned SLEEP_BIT    = 4;
  localparam int unsigned NAP_W        = 4;

  // Sample path.
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned SAMPLE_W = 14;

  typedef logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_set_t;

  // Output and clock modes handed to the converter core.
  typedef struct packed {
    logic lane_single;
    logic lvds_low_current;
    logic termination_on;
    logic duty_stabilizer_disable;
    logic output_scramble_enable;
    logic signed_format_select;
  } mode_t;

  // Power controls handed to the analog core.
  typedef struct packed {
    logic [CHANNELS-1:0] channel_power_down;
    logic                reference_power_down;
    logic                pll_power_down;
  } power_t;

  // Formats one offset-binary core sample for the output pins.
  function automatic logic [SAMPLE_W-1:0] format_sample(
    input logic [SAMPLE_W-1:0] raw,
    input logic                signed_sel,
    input logic                scramble);
    logic [SAMPLE_W-1:0] r;
    r = signed_sel ? {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]} : raw;
    if (scramble)
    begin
      r[SAMPLE_W-1:1] = r[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){r[0]}};
    end
    return r;
  endfunction : format_sample

endpackage : adc_cfg_pkg

`default_nettype wire

// file: src/cfg_reg_file.sv
// Mode control register storage with a registered read port.
`timescale 1ns/1ns
`default_nettype none

module cfg_reg_file (
  // Clock and reset.
  input  wire logic                            clock,
  input  wire logic                            rst,
  // Write side.
  input  wire logic                            clear,
  input  wire logic                            wr_en,
  input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [adc_cfg_pkg::DATA_W-1:0]  wr_data,
  // Read side.
  input  wire logic                            rd_en,
  input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  rd_addr,
  input  wire logic                            reset_busy,
  output logic      [adc_cfg_pkg::DATA_W-1:0]  rd_data,
  // Live contents.
  output logic      [adc_cfg_pkg::DATA_W-1:0]  format_value
);

  // Format register; clear wins since a soft reset must leave all zero.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      format_value <= adc_cfg_pkg::FORMAT_RESET;
    else if (clear)
      format_value <= adc_cfg_pkg::FORMAT_RESET;
    else if (wr_en && wr_addr == adc_cfg_pkg::ADDR_FORMAT_PD)
      format_value <= wr_data;
  end

  // Read data; the reset register shows only its busy bit, others read 0.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rd_data <= '0;
    else if (rd_en)
    begin
      case (rd_addr)
        adc_cfg_pkg::ADDR_SOFT_RESET:
          rd_data <= {reset_busy, 7'h00};
        adc_cfg_pkg::ADDR_FORMAT_PD:
          rd_data <= format_value;
        default:
          rd_data <= '0;
      endcase
    end
  end

endmodule : cfg_reg_file

`default_nettype wire

// file: src/adc_mode_config_port.sv
// Strap or serial mode configuration port of the quad converter.
`timescale 1ns/1ns
`default_nettype none

module adc_mode_config_port #(
  parameter int unsigned WAKE_CYCLES = adc_cfg_pkg::SLEEP_WAKE_CYCLES
) (
  // Clock and reset.
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Configuration pins.
  input  wire logic                     interface_select_strap,
  input  wire logic                     cs_n_pin,
  input  wire logic                     sck_pin,
  input  wire logic                     sdi_pin,
  input  wire logic                     sdo_in,
  output logic                          sdo_out,
  output logic                          sdo_oe,
  // Converter controls.
  output adc_cfg_pkg::mode_t            mode,
  output adc_cfg_pkg::power_t           power,
  output logic                          conversions_valid,
  // Sample path.
  input  wire adc_cfg_pkg::sample_set_t sample_in,
  output adc_cfg_pkg::sample_set_t      sample_out
);

  localparam int unsigned WAKE_W = $clog2(WAKE_CYCLES + 1);

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_HEAD = 3'b010,
    LINK_BODY = 3'b100
  } link_state_t;

  link_state_t       state_reg;
  link_state_t       state_next;
  logic [4:0]        sync1_reg;
  logic [4:0]        sync2_reg;
  logic              sck_prev_reg;
  logic              cs_prev_reg;
  logic [4:0]        bit_cnt_reg;
  logic [15:0]       shift_in_reg;
  logic              read_active_reg;
  logic              load_pending_reg;
  logic [7:0]        sdo_shift_reg;
  logic              sdo_bit_reg;
  logic [2:0]        busy_cnt_reg;
  logic [WAKE_W-1:0] wake_cnt_reg;
  logic [7:0]        rd_data;
  logic [7:0]        format_value;

  logic strap_s;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic head_done;
  logic rd_en;
  logic commit;
  logic wr_en;
  logic soft_start;
  logic reset_busy;
  logic sleep_req;
  logic [adc_cfg_pkg::NAP_W-1:0] nap_req;

  // Every pin is foreign to this clock, so each passes two flops first.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      // The select bit resets to its idle high level, so no false fall.
      sync1_reg <= 5'h08;
      sync2_reg <= 5'h08;
    end
    else
    begin
      sync1_reg <= {interface_select_strap, cs_n_pin, sck_pin, sdi_pin,
                    sdo_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign strap_s = sync2_reg[4];
  assign cs_s    = sync2_reg[3];
  assign sck_s   = sync2_reg[2];
  assign sdi_s   = sync2_reg[1];
  assign sdo_s   = sync2_reg[0];

  // Previous levels for edge detection; select idles high after reset.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      cs_prev_reg  <= cs_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;
  assign cs_fall  = ~cs_s & cs_prev_reg;

  // Header complete: the eighth rising edge is being taken right now.
  assign head_done = (state_reg == LINK_HEAD) && sck_rise &&
                     (bit_cnt_reg == 5'(adc_cfg_pkg::HEAD_BITS - 1));

  // Transfer sequencing; the serial path only exists with the strap low.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LINK_IDLE:
        if (!strap_s && cs_fall)
          state_next = LINK_HEAD;
      LINK_HEAD:
        if (cs_s || strap_s)
          state_next = LINK_IDLE;
        else if (head_done)
          state_next = LINK_BODY;
      LINK_BODY:
        if (cs_s || strap_s)
          state_next = LINK_IDLE;
      default:
        state_next = LINK_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= LINK_IDLE;
    else
      state_reg <= state_next;
  end

  // Input shifter; edges past the sixteenth are dropped on purpose.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg  <= 5'h00;
      shift_in_reg <= 16'h0000;
    end
    else if (state_reg == LINK_IDLE)
      bit_cnt_reg <= 5'h00;
    else if (sck_rise && bit_cnt_reg < 5'(adc_cfg_pkg::WORD_BITS))
    begin
      bit_cnt_reg  <= bit_cnt_reg + 5'h01;
      shift_in_reg <= {shift_in_reg[14:0], sdi_s};
    end
  end

  // Only a full word closed by a clean select rise may write.
  assign commit = (state_reg == LINK_BODY) && cs_s && !strap_s &&
                  (bit_cnt_reg == 5'(adc_cfg_pkg::WORD_BITS));
  assign wr_en  = commit && !shift_in_reg[15];

  // Soft reset: bit 7 of register 0 starts a short self-timed pulse.
  assign soft_start = wr_en && shift_in_reg[adc_cfg_pkg::RESET_BIT] &&
                      (shift_in_reg[14:8] == adc_cfg_pkg::ADDR_SOFT_RESET);
  assign reset_busy = (busy_cnt_reg != 3'h0);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      busy_cnt_reg <= 3'h0;
    else if (soft_start)
      busy_cnt_reg <= 3'(adc_cfg_pkg::SOFT_RESET_CYCLES);
    else if (reset_busy)
      busy_cnt_reg <= busy_cnt_reg - 3'h1;
  end

  // The read flag sits in bit 6 as the eighth bit arrives.
  assign rd_en = head_done && shift_in_reg[6];

  cfg_reg_file u_regs (
    .clock        (clock),
    .rst          (rst),
    .clear        (soft_start),
    .wr_en        (wr_en),
    .wr_addr      (shift_in_reg[14:8]),
    .wr_data      (shift_in_reg[7:0]),
    .rd_en        (rd_en),
    .rd_addr      ({shift_in_reg[5:0], sdi_s}),
    .reset_busy   (reset_busy),
    .rd_data      (rd_data),
    .format_value (format_value)
  );

  // Readback control; register data lands one cycle after the request.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      read_active_reg  <= 1'b0;
      load_pending_reg <= 1'b0;
    end
    else
    begin
      load_pending_reg <= rd_en;
      if (state_reg == LINK_IDLE)
        read_active_reg <= 1'b0;
      else if (rd_en)
        read_active_reg <= 1'b1;
    end
  end

  // Data out changes on falling clock so the host samples it on rising.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sdo_shift_reg <= 8'h00;
      sdo_bit_reg   <= 1'b1;
    end
    else if (state_reg == LINK_IDLE)
      sdo_bit_reg <= 1'b1;
    else if (load_pending_reg)
      sdo_shift_reg <= rd_data;
    else if (read_active_reg && sck_fall)
    begin
      if (bit_cnt_reg < 5'(adc_cfg_pkg::WORD_BITS))
      begin
        sdo_bit_reg   <= sdo_shift_reg[7];
        sdo_shift_reg <= {sdo_shift_reg[6:0], 1'b0};
      end
      else
        sdo_bit_reg <= 1'b1;
    end
  end

  // Open drain: a one is only a released pin, the pull-up makes the level.
  assign sdo_out = 1'b0;
  assign sdo_oe  = ~sdo_bit_reg;

  // Power request: strap pin, or sleep bit over naps, or soft reset.
  assign sleep_req = strap_s ? sdi_s
                   : (format_value[adc_cfg_pkg::SLEEP_BIT] ||
                      reset_busy);
  assign nap_req   = (strap_s || sleep_req) ? '0
                   : format_value[adc_cfg_pkg::NAP_W-1:0];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      power <= '0;
    else
    begin
      power.channel_power_down <= sleep_req ? '1 : nap_req;
      power.reference_power_down <= sleep_req;
      power.pll_power_down <= sleep_req;
    end
  end

  // Wake timer; the core is assumed unsettled right after a hard reset too.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_cnt_reg      <= WAKE_W'(WAKE_CYCLES);
      conversions_valid <= 1'b0;
    end
    else if (sleep_req)
    begin
      wake_cnt_reg      <= WAKE_W'(WAKE_CYCLES);
      conversions_valid <= 1'b0;
    end
    else if (wake_cnt_reg != '0)
    begin
      wake_cnt_reg      <= wake_cnt_reg - WAKE_W'(1);
      conversions_valid <= 1'b0;
    end
    else
      conversions_valid <= 1'b1;
  end

  // Modes: strap pins steer output setup, register bits steer format.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mode <= '0;
    else
    begin
      mode.lane_single      <= strap_s & cs_s;
      mode.lvds_low_current <= strap_s & sck_s;
      mode.termination_on   <= strap_s & sdo_s;
      mode.duty_stabilizer_disable <= !strap_s &&
        format_value[adc_cfg_pkg::DCS_OFF_BIT];
      mode.output_scramble_enable <= !strap_s &&
        format_value[adc_cfg_pkg::SCRAMBLE_BIT];
      mode.signed_format_select <= !strap_s &&
        format_value[adc_cfg_pkg::SIGNED_BIT];
    end
  end

  // Sample formatting, one register stage per channel.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sample_out <= '0;
    else
    begin
      for (int i = 0; i < adc_cfg_pkg::CHANNELS; i++)
      begin
        sample_out[i] <= adc_cfg_pkg::format_sample(sample_in[i],
          mode.signed_format_select,
          mode.output_scramble_enable);
      end
    end
  end

  // Checks kept next to the logic they guard.
  a_sleep_all_down: assert property (
    @(posedge clock) disable iff (rst)
    sleep_req |=> (power.channel_power_down == 4'hF &&
                   power.reference_power_down && power.pll_power_down))
    else $error("sleep left part of the converter powered");

  a_wake_holdoff: assert property (
    @(posedge clock) disable iff (rst)
    $fell(power.pll_power_down) |-> !conversions_valid [*8])
    else $error("conversions valid too soon after sleep");

  a_nap_keeps_refs: assert property (
    @(posedge clock) disable iff (rst)
    (!sleep_req && nap_req != 4'h0) |=>
      (!power.reference_power_down && !power.pll_power_down &&
       power.channel_power_down == $past(nap_req)))
    else $error("nap touched references or wrong channels");

  a_strap_pins_mode: assert property (
    @(posedge clock) disable iff (rst)
    (strap_s && $stable(strap_s)) |=>
      (mode.lane_single == $past(cs_s) &&
       mode.termination_on == $past(sdo_s) && !sdo_oe))
    else $error("strap pins not followed");

  a_edge_cap: assert property (
    @(posedge clock) disable iff (rst)
    (bit_cnt_reg == 5'h10 && sck_rise) |=> $stable(shift_in_reg))
    else $error("edge after the sixteenth was sampled");

  a_void_short: assert property (
    @(posedge clock) disable iff (rst)
    (cs_s && bit_cnt_reg != 5'h10) |-> !wr_en)
    else $error("short transfer wrote a register");

  a_read_no_write: assert property (
    @(posedge clock) disable iff (rst)
    (read_active_reg && commit) |-> !wr_en)
    else $error("readback modified a register");

  a_reset_selfclear: assert property (
    @(posedge clock) disable iff (rst)
    soft_start |=> reset_busy [*4] ##1 !reset_busy)
    else $error("soft reset bit did not clear after four cycles");

  a_reset_sleeps: assert property (
    @(posedge clock) disable iff (rst)
    soft_start |=> (format_value == 8'h00) ##1 power.pll_power_down)
    else $error("soft reset did not clear or sleep");

  a_strap_dcs_on: assert property (
    @(posedge clock) disable iff (rst)
    strap_s |=> !mode.duty_stabilizer_disable)
    else $error("stabilizer off in strap mode");

  a_scramble_lsb: assert property (
    @(posedge clock) disable iff (rst)
    (mode.output_scramble_enable && !mode.signed_format_select) |=>
      (sample_out[0][13:1] ==
       ($past(sample_in[0][13:1]) ^ {13{$past(sample_in[0][0])}})))
    else $error("scrambler output wrong");

endmodule : adc_mode_config_port

`default_nettype wire

// file: sim/cfg_host_model.sv
// Host controller model that drives the serial configuration pins.
`timescale 1ns/1ns
`default_nettype none

module cfg_host_model (
  // Pacing clock.
  input  wire logic clock,
  // Serial pins.
  input  wire logic sdo_line,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  // Pins idle with select high and the serial clock still.
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end

  // Holds a pin level for four system clocks, then steps off the edge.
  task automatic hold();
    repeat (4) @(posedge clock);
    #1;
  endtask : hold

  // Sends nbits clocks, word MSB first; clocks past 16 carry toggling data.
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [7:0] rdata);
    rdata = 8'h00;
    cs_n  = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      sdi = (i < 16) ? word[15-i] : ~sdi;
      hold();
      sck = 1'b1;
      hold();
      // The data bit stands until the fall, so sampling late is safe.
      if (i >= 8 && i < 16)
        rdata = {rdata[6:0], sdo_line};
      sck = 1'b0;
    end
    hold();
    cs_n = 1'b1;
    // A released data line must not keep its last value.
    sdi  = ~sdi;
    hold();
  endtask : xfer

endmodule : cfg_host_model

`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the mode configuration port with a host model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(64'(g), 64'(e))

module tb_top;
  localparam int WAKE = 20;
  logic                     clock    = 1'b0;
  logic                     rst      = 1'b1;
  logic                     strap    = 1'b0;
  logic [3:0]               spin     = 4'h0;
  adc_cfg_pkg::sample_set_t s_in     = '0;
  adc_cfg_pkg::sample_set_t s_out;
  adc_cfg_pkg::mode_t       mode;
  adc_cfg_pkg::power_t      power;
  logic                     h_cs;
  logic                     h_sck;
  logic                     h_sdi;
  logic                     sdo_out;
  logic                     sdo_oe;
  logic                     valid;
  wire                      sdo_wire;
  int                       err_count = 0;
  int                       checked   = 0;
  int                       cycles    = 0;
  int                       fmt_m     = 0;
  logic [7:0]               rd;
  logic [7:0]               v;
  logic [6:0]               a;

  // The data-out wire has a pull-up; the device can only pull it low.
  assign sdo_wire = sdo_oe ? sdo_out : 1'b1;

  always #10 clock = ~clock;

  adc_mode_config_port #(.WAKE_CYCLES(WAKE)) u_dut (
    .clock(clock), .rst(rst), .interface_select_strap(strap),
    .cs_n_pin(strap ? spin[3] : h_cs), .sck_pin(strap ? spin[2] : h_sck),
    .sdi_pin(strap ? spin[1] : h_sdi), .sdo_in(strap ? spin[0] : sdo_wire),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .mode(mode), .power(power),
    .conversions_valid(valid), .sample_in(s_in), .sample_out(s_out));

  cfg_host_model u_host (
    .clock(clock), .sdo_line(sdo_wire), .cs_n(h_cs), .sck(h_sck),
    .sdi(h_sdi));

  // Compares one value and counts the outcome.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checks: %0d, mismatches: %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] ad, input logic [7:0] d, input int n);
    logic [7:0] x;
    u_host.xfer({1'b0, ad, d}, n, x);
    tick(6);
  endtask : wr

  // Reads with random input data, which the device must ignore.
  task automatic rdr(input logic [6:0] ad, output logic [7:0] d);
    u_host.xfer({1'b1, ad, 8'($urandom)}, 16, d);
    tick(2);
  endtask : rdr

  // Reference output formatting: sign flip, then LSB folded into the rest.
  function automatic logic [13:0] fmt_exp(input logic [13:0] raw,
                                          input int f);
    logic [13:0] r;
    r = raw ^ (f[5] ? 14'h2000 : 14'h0000);
    if (f[6])
      r[13:1] = r[13:1] ^ {13{r[0]}};
    return r;
  endfunction : fmt_exp

  // Checks every output that the format register drives, then reads it back.
  task automatic check_fmt();
    logic [5:0] pw;
    pw = fmt_m[4] ? 6'h3F : {fmt_m[3:0], 2'b00};
    `CHK(mode, {3'b000, fmt_m[7:5]});
    `CHK(power, pw);
    `CHK(valid, !fmt_m[4]);
    for (int c = 0; c < 4; c++)
      `CHK(s_out[c], fmt_exp(s_in[c], fmt_m));
    rdr(7'h01, rd);
    `CHK(rd, fmt_m[7:0]);
  endtask : check_fmt

  // Cuts a hang short.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(32'hA208));
    tick(16);
    rst = 1'b0;
    tick(WAKE - 4);
    `CHK(valid, 0);
    tick(8);
    `CHK(valid, 1);
    // Soft reset goes first; it sleeps the converter for a while.
    wr(7'h00, 8'h80, 16);
    `CHK(valid, 0);
    tick(40);
    rdr(7'h00, rd);
    `CHK(rd, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'h1F : (i == 1) ? 8'hEF : 8'($urandom);
      s_in = 56'({$urandom, $urandom});
      wr(7'h01, v, 16);
      fmt_m = v;
      tick(100);
      check_fmt();
      check_fmt();
    end
    // A short transfer is void; extra clocks past 16 are ignored.
    wr(7'h01, ~v, 15);
    check_fmt();
    v = 8'($urandom) | 8'h20;
    wr(7'h01, v, 19);
    fmt_m = v;
    tick(100);
    check_fmt();
    a = 7'(2 + $urandom_range(125));
    wr(a, 8'hFF, 16);
    rdr(a, rd);
    `CHK(rd, 8'h00);
    check_fmt();
    `CHK(sdo_out, 0);
    wr(7'h00, 8'h80, 16);
    fmt_m = 0;
    tick(60);
    check_fmt();
    // Strap mode: the four pins become static mode inputs.
    strap = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      spin = 4'(i);
      tick(8);
      `CHK(mode[5], spin[3]);
      `CHK(mode[4], spin[2]);
      `CHK(mode[3], spin[0]);
      `CHK(mode[2:0], 3'b000);
      `CHK(power, spin[1] ? 6'h3F : 6'h00);
      `CHK(sdo_oe, 0);
    end
    strap = 1'b0;
    tick(10);
    conclude();
  end

endmodule : tb_top

`default_nettype wire
